// ---- hdl/press_mon_defs.svh ----
/*
  Constants of the press contact fault monitor: timing, addresses,
  register bit positions and reset values.
  Assumes a 125 MHz controller clock.
*/
`ifndef PRESS_MON_DEFS_SVH
`define PRESS_MON_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define PM_CLK_HZ       64'd125000000
`define PM_CLR_SHORT_MS 64'd100
`define PM_CLR_LONG_MS  64'd350
`define PM_CLR_MAX_S    64'd30
// Least times round up, the longest time rounds down
`define PM_SHORT_CYC ((`PM_CLK_HZ*`PM_CLR_SHORT_MS+64'd999)/64'd1000)
`define PM_LONG_CYC  ((`PM_CLK_HZ*`PM_CLR_LONG_MS+64'd999)/64'd1000)
`define PM_MAX_CYC   (`PM_CLK_HZ*`PM_CLR_MAX_S)

// ----------------------------------------
// Register map
// ----------------------------------------
`define PM_ADDR_CTRL 4'h0
`define PM_ADDR_STAT 4'h4
`define PM_CTRL_RST  6'h00
`define PM_RESP_OK   2'h0
`define PM_RESP_DEC  2'h3
// Control bits
`define PM_B_CLR_EN 0
`define PM_B_LONG   1
`define PM_B_MULTI  2
`define PM_B_ANY    3
`define PM_B_ADV    4
`define PM_B_COAST  5
// Status bits
`define PM_S_PERMIT 0
`define PM_S_TOP    1
`define PM_S_UP     2
`define PM_S_PEND   3
`define PM_S_SEQ    4
`define PM_S_OVR    5
`define PM_S_ANY    6

`endif

// ---- hdl/press_mon_pkg.sv ----
/*
  Types of the press contact fault monitor.
  Assumes press_mon_defs.svh supplies all numeric constants.
*/
package press_mon_pkg;

  // Cycle phase, one-hot
  typedef enum logic [2:0] {
    PH_TOP  = 3'b001,
    PH_DOWN = 3'b010,
    PH_UP   = 3'b100
  } phase_t;

  // Sampled contact and pin levels
  typedef struct packed {
    logic top;
    logic bot;
    logic adv;
    logic coast;
    logic permit;
    logic clr;
  } pins_t;

  // State of the monitor, all but the clear pulse timer
  typedef struct packed {
    pins_t       s1;
    pins_t       s2;
    pins_t       p;
    logic        drv_p;
    phase_t      phase;
    logic [1:0]  bcnt;
    logic        start_seen;
    logic        adv_dn;
    logic        top_zone;
    logic        up;
    logic        permit;
    logic        pend;
    logic        seq;
    logic        ovr;
    logic        anyf;
    logic [5:0]  ctrl;
    logic        aw_ok;
    logic [3:0]  awa;
    logic        w_ok;
    logic [31:0] wd;
    logic        wst;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } mon_st_t;

  // State of the clear pulse timer
  typedef struct packed {
    logic [31:0] cnt;
    logic        armed;
    logic        lvl_p;
    logic        acc;
  } clr_st_t;

endpackage

// ---- hdl/clear_pulse_timer.sv ----
/*
  Fault-clear pulse qualifier: measures the high phase of an already
  synchronised request and flags a valid low-high-low pulse.
  Assumes level is in the aclk domain.
*/
`timescale 1ns/1ps
`default_nettype none
module clear_pulse_timer
  import press_mon_pkg::*;
#(
  parameter logic [31:0] SHORT_CYC = 32'd12500000,
  parameter logic [31:0] LONG_CYC  = 32'd43750000,
  parameter logic [31:0] MAX_CYC   = 32'd3750000000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic enable,
  input  wire logic long_sel,
  input  wire logic level,
  output logic      accept
);

  clr_st_t     q;
  clr_st_t     n;
  logic [31:0] min_cyc;

  assign min_cyc = long_sel ? LONG_CYC : SHORT_CYC;
  assign accept  = q.acc;

  // ----------------------------------------
  // Pulse measurement
  // ----------------------------------------
  // A high phase seen at reset or enable is not armed: low must come first
  always_comb begin
    n       = q;
    n.acc   = 1'b0;
    n.lvl_p = level;
    if (!enable) begin
      n.armed = 1'b0;
      n.cnt   = '0;
    end else if (!level) begin
      if (q.lvl_p && q.armed && q.cnt >= min_cyc && q.cnt <= MAX_CYC) begin
        n.acc = 1'b1;
      end
      n.armed = 1'b1;
      n.cnt   = '0;
    end else if (q.armed && q.cnt <= MAX_CYC) begin
      n.cnt = q.cnt + 32'h1; // Saturates one past the limit
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else if (ce) begin
      q <= n;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_acc_min;
    $rose(accept) |-> $past(q.cnt) >= $past(min_cyc);
  endproperty
  a_acc_min: assert property (p_acc_min) else $error("clear pulse too short");

  property p_acc_max;
    $rose(accept) |-> $past(q.cnt) <= MAX_CYC && !$past(level);
  endproperty
  a_acc_max: assert property (p_acc_max) else $error("clear pulse too long");

  property p_acc_off;
    ce && !enable |=> !accept;
  endproperty
  a_acc_off: assert property (p_acc_off) else $error("clear taken while off");

endmodule
`default_nettype wire

// ---- hdl/press_contact_fault_monitor.sv ----
/*
  Press cycle contact monitor with AXI4-Lite control and status.
  Watches top, bottom, advance and coast-zone contacts, drives the
  press permit, top-zone and upstroke outputs and latches faults.
  Assumes contacts, permit and clear request are asynchronous pins,
  drive_active comes from logic on aclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "press_mon_defs.svh"
module press_contact_fault_monitor
  import press_mon_pkg::*;
#(
  parameter logic [31:0] SHORT_CYC = 32'(`PM_SHORT_CYC),
  parameter logic [31:0] LONG_CYC  = 32'(`PM_LONG_CYC),
  parameter logic [31:0] MAX_CYC   = 32'(`PM_MAX_CYC)
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        top_position_contact,
  input  wire logic        bottom_position_contact,
  input  wire logic        advance_contact,
  input  wire logic        coast_zone_contact,
  input  wire logic        permit_in,
  input  wire logic        fault_clear_request,
  input  wire logic        drive_active,
  output logic             press_permit,
  output logic             top_zone,
  output logic             upstroke_phase,
  output logic             reset_pending,
  output logic             sequence_fault,
  output logic             overrun_fault,
  output logic             any_fault,
  input  wire logic [3:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [3:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);

  mon_st_t q;
  mon_st_t n;
  pins_t   pins;
  pins_t   c;
  pins_t   pv;
  logic    top_r;
  logic    top_f;
  logic    bot_r;
  logic    bot_f;
  logic    adv_f;
  logic    drv_r;
  logic    multi;
  logic    adv_on;
  logic    mon;
  logic    seq_evt;
  logic    ovr_evt;
  logic    stop_req;
  logic    clr_acc;
  logic    clr_take;
  logic    fault_n;
  logic [1:0]  bmax;
  logic [31:0] stat;

  // ----------------------------------------
  // Input sampling
  // ----------------------------------------
  assign pins = '{top: top_position_contact, bot: bottom_position_contact,
                  adv: advance_contact, coast: coast_zone_contact,
                  permit: permit_in, clr: fault_clear_request};
  // Contact edges compare the settled sample with the one before, the drive edge the live input
  assign c     = q.s2;
  assign pv    = q.p;
  assign top_r = c.top & ~pv.top;
  assign top_f = ~c.top & pv.top;
  assign bot_r = c.bot & ~pv.bot;
  assign bot_f = ~c.bot & pv.bot;
  assign adv_f = ~c.adv & pv.adv;
  assign drv_r = drive_active & ~q.drv_p;

  assign multi  = q.ctrl[`PM_B_MULTI];
  assign adv_on = q.ctrl[`PM_B_ADV];
  assign bmax   = multi ? 2'd2 : 2'd1;
  // Checks pause on low permit, its first sample back (false edges after reset) or a fault
  assign mon    = c.permit & pv.permit & ~q.pend;

  // ----------------------------------------
  // Clear request qualification
  // ----------------------------------------
  clear_pulse_timer #(
    .SHORT_CYC (SHORT_CYC),
    .LONG_CYC  (LONG_CYC),
    .MAX_CYC   (MAX_CYC)
  ) u_clr (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .enable   (q.ctrl[`PM_B_CLR_EN]),
    .long_sel (q.ctrl[`PM_B_LONG]),
    .level    (c.clr),
    .accept   (clr_acc)
  );
  assign clr_take = clr_acc & q.ctrl[`PM_B_CLR_EN];

  // ----------------------------------------
  // Fault detection
  // ----------------------------------------
  // Stopped means no drive start seen in the top area and drive off now
  assign stop_req = ~q.start_seen & ~drive_active;
  assign ovr_evt  = mon & top_f & stop_req;

  always_comb begin
    seq_evt = 1'b0;
    // Single mode: bottom rises while on top, falls while off top
    if (!multi && bot_r && c.top) seq_evt = 1'b1;
    if (!multi && bot_f && !c.top) seq_evt = 1'b1;
    if (!multi && top_f && c.bot) seq_evt = 1'b1;
    if (!multi && top_r && q.bcnt != 2'd1) seq_evt = 1'b1;
    if (bot_r && q.bcnt == bmax) seq_evt = 1'b1;
    // Advance may only fall away from the top contact
    if (adv_on && adv_f && c.top) seq_evt = 1'b1;
    // Coast zone and top must never both be low
    if (q.ctrl[`PM_B_COAST] && !c.coast && !c.top) seq_evt = 1'b1;
    seq_evt = seq_evt & mon;
  end

  // ----------------------------------------
  // Register file decode
  // ----------------------------------------
  assign stat = {25'h0, q.anyf, q.ovr, q.seq, q.pend, q.up, q.top_zone, q.permit};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n       = q;
    n.s1    = pins;
    n.s2    = q.s1;
    n.p     = q.s2;
    n.drv_p = drive_active;

    // Cycle tracking
    if (!c.permit) begin
      // Resync tracking so a resumed cycle is not misjudged
      n.phase      = c.top ? PH_TOP : (c.bot ? PH_UP : PH_DOWN);
      n.bcnt       = {1'b0, c.bot & ~c.top};
      n.start_seen = 1'b1;
    end else begin
      if (top_f) begin
        n.phase      = PH_DOWN;
        n.bcnt       = 2'd0;
        n.start_seen = 1'b0;
        n.adv_dn     = 1'b0;
      end
      if (bot_r) begin
        n.phase = PH_UP;
        if (q.bcnt != 2'd3) n.bcnt = q.bcnt + 2'd1;
      end
      if (top_r) n.phase = PH_TOP;
      if (drv_r && q.top_zone) n.start_seen = 1'b1;
      if (adv_on && adv_f && !c.bot) n.adv_dn = 1'b1;
    end

    // Top area: entered by top rise or advance fall, left by top fall or a bottom rise off top
    if (top_f || (bot_r && !c.top)) n.top_zone = 1'b0;
    if (top_r || (adv_on && adv_f)) n.top_zone = 1'b1;

    // Upstroke: first bottom rise until top, advance or, in multi mode, a bottom fall ends it
    if (top_r || (adv_on && adv_f) || (multi && bot_f)) n.up = 1'b0;
    else if (bot_r && q.bcnt == 2'd0 && !n.adv_dn) n.up = 1'b1;

    // Latched faults, a new fault wins over a clear in the same cycle
    n.seq  = (q.seq & ~clr_take) | seq_evt;
    n.ovr  = (q.ovr & ~clr_take) | ovr_evt;
    n.pend = (q.pend & ~clr_take) | seq_evt | ovr_evt;
    fault_n = n.seq | n.ovr;
    if (clr_take && !fault_n) begin
      n.top_zone = c.top;
      n.up       = 1'b0;
    end
    if (fault_n) begin
      n.top_zone = 1'b0;
      n.up       = 1'b0;
    end
    n.anyf   = q.ctrl[`PM_B_ANY] & fault_n;
    n.permit = c.permit & ~n.pend;

    // AXI write: address and data taken in either order
    if (awvalid && awready) begin
      n.aw_ok = 1'b1;
      n.awa   = awaddr;
    end
    if (wvalid && wready) begin
      n.w_ok = 1'b1;
      n.wd   = wdata;
      n.wst  = wstrb[0];
    end
    if (q.aw_ok && q.w_ok) begin
      n.aw_ok  = 1'b0;
      n.w_ok   = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = `PM_RESP_OK;
      if (q.awa == `PM_ADDR_CTRL) begin
        if (q.wst) n.ctrl = q.wd[5:0];
      end else if (q.awa == `PM_ADDR_STAT) begin
        n.bresp = `PM_RESP_OK; // Read-only, write dropped
      end else begin
        n.bresp = `PM_RESP_DEC;
      end
    end
    if (q.bvalid && bready) n.bvalid = 1'b0;

    // AXI read
    if (q.rvalid && rready) n.rvalid = 1'b0;
    if (arvalid && arready) begin
      n.rvalid = 1'b1;
      n.rresp  = `PM_RESP_OK;
      if (araddr == `PM_ADDR_CTRL) begin
        n.rdata = {26'h0, q.ctrl};
      end else if (araddr == `PM_ADDR_STAT) begin
        n.rdata = stat;
      end else begin
        n.rdata = 32'h0;
        n.rresp = `PM_RESP_DEC;
      end
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Clock enable low freezes everything, bus handshakes included
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q       <= '0;
      q.phase <= PH_TOP;
      q.ctrl  <= `PM_CTRL_RST;
    end else if (ce) begin
      q <= n;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign press_permit   = q.permit;
  assign top_zone       = q.top_zone;
  assign upstroke_phase = q.up;
  assign reset_pending  = q.pend;
  assign sequence_fault = q.seq;
  assign overrun_fault  = q.ovr;
  assign any_fault      = q.anyf;
  // Readies drop while ce is low, so frozen state never misses a transfer
  assign awready = ~q.aw_ok & ~q.bvalid & ce;
  assign wready  = ~q.w_ok & ~q.bvalid & ce;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = ~q.rvalid & ce;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_fault_zones;
    (sequence_fault || overrun_fault) |-> !top_zone && !upstroke_phase;
  endproperty
  a_fault_zones: assert property (p_fault_zones) else $error("zone out during fault");

  property p_pend_set;
    $rose(sequence_fault) || $rose(overrun_fault) |-> reset_pending;
  endproperty
  a_pend_set: assert property (p_pend_set) else $error("fault without pending");

  property p_pend_drop;
    $fell(reset_pending) |-> $past(clr_take);
  endproperty
  a_pend_drop: assert property (p_pend_drop) else $error("pending dropped unasked");

  property p_pend_permit;
    reset_pending |-> !press_permit;
  endproperty
  a_pend_permit: assert property (p_pend_permit) else $error("permit while pending");

  property p_seq_set;
    ce && seq_evt |=> sequence_fault;
  endproperty
  a_seq_set: assert property (p_seq_set) else $error("sequence fault missed");

  property p_ovr_cause;
    $rose(overrun_fault) |-> $past(top_f && stop_req && mon);
  endproperty
  a_ovr_cause: assert property (p_ovr_cause) else $error("overrun without cause");

  property p_any;
    q.ctrl[`PM_B_ANY] && (sequence_fault || overrun_fault) |-> any_fault;
  endproperty
  a_any: assert property (p_any) else $error("any_fault missing");

  property p_seq_hold;
    sequence_fault && !clr_take |=> sequence_fault;
  endproperty
  a_seq_hold: assert property (p_seq_hold) else $error("sequence fault lost");

  property p_ovr_hold;
    overrun_fault && !clr_take |=> overrun_fault;
  endproperty
  a_ovr_hold: assert property (p_ovr_hold) else $error("overrun fault lost");

  property p_clr_off;
    !q.ctrl[`PM_B_CLR_EN] && reset_pending |=> reset_pending;
  endproperty
  a_clr_off: assert property (p_clr_off) else $error("clear honoured while off");

  property p_permit_in;
    ce && !c.permit |=> !press_permit;
  endproperty
  a_permit_in: assert property (p_permit_in) else $error("permit with input low");

  c_seq:   cover property ($rose(sequence_fault));
  c_ovr:   cover property ($rose(overrun_fault));
  c_clear: cover property ($fell(reset_pending));
  c_cycle: cover property ($rose(upstroke_phase) ##[1:1000] $rose(top_zone));

endmodule
`default_nettype wire

// ---- dv/press_model.sv ----
/*
  Far-side model: position contacts of the press and the downstream
  control lines (drive command, stop source, clear request button).
  Assumes the bench calls its tasks and shares the monitor's aclk.
*/
`timescale 1ns/1ps
`default_nettype none
module press_model (
  input  wire logic aclk,
  output logic      top,
  output logic      bot,
  output logic      adv,
  output logic      coast,
  output logic      permit,
  output logic      clr,
  output logic      drive
);
  // ----------------------------------------
  // Idle press parked at top, drive off
  // ----------------------------------------
  initial begin
    top = 1'b1;
    bot = 1'b0;
    adv = 1'b1;
    coast = 1'b1;
    permit = 1'b1;
    clr = 1'b0;
    drive = 1'b0;
  end
  // Contacts move only just after an edge
  task automatic set_pins(input logic t, input logic b, input logic a, input logic c);
    @(posedge aclk);
    top <= t;
    bot <= b;
    adv <= a;
    coast <= c;
  endtask
  // Drive command from the same clock domain
  task automatic set_drive(input logic v);
    @(posedge aclk);
    drive <= v;
  endtask
  // Stop source, low whenever motion must halt
  task automatic set_permit(input logic v);
    @(posedge aclk);
    permit <= v;
  endtask
  // Low-high-low button press, n cycles high
  task automatic pulse(input int n);
    @(posedge aclk);
    clr <= 1'b1;
    repeat (n) @(posedge aclk);
    clr <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ---- dv/press_contact_fault_monitor_bench.sv ----
/*
  Self-checking bench of the press contact fault monitor.
  Assumes short sim timing (20/40/200 cycles) and the press_model partner.
*/
`timescale 1ns/1ps
`default_nettype none
`include "press_mon_defs.svh"
module press_contact_fault_monitor_bench;
  import press_mon_pkg::*;
  logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready;
  logic [3:0] awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid;
  logic press_permit, top_zone, upstroke_phase, reset_pending;
  logic sequence_fault, overrun_fault, any_fault;
  logic top, bot, adv, coast, permit, clr, drive;
  logic [65:0] rq[$];
  logic [65:0] e;
  int num_errors = 0;
  int comparisons = 0;
  // ----------------------------------------
  // Clock, design and partner
  // ----------------------------------------
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  press_model i_press (.aclk(aclk), .top(top), .bot(bot), .adv(adv), .coast(coast),
    .permit(permit), .clr(clr), .drive(drive));
  press_contact_fault_monitor #(.SHORT_CYC(32'd20), .LONG_CYC(32'd40), .MAX_CYC(32'd200))
  i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .top_position_contact(top),
    .bottom_position_contact(bot), .advance_contact(adv), .coast_zone_contact(coast),
    .permit_in(permit), .fault_clear_request(clr), .drive_active(drive),
    .press_permit(press_permit), .top_zone(top_zone), .upstroke_phase(upstroke_phase),
    .reset_pending(reset_pending), .sequence_fault(sequence_fault),
    .overrun_fault(overrun_fault), .any_fault(any_fault), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));
  // ----------------------------------------
  // Result watcher: oldest note against each read answer
  // ----------------------------------------
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready === 1'b1) begin
      comparisons++;
      if (bresp !== `PM_RESP_OK) begin
        num_errors++;
        $display("BAD %0t write response %h", $time, bresp);
      end
    end
    if (rvalid === 1'b1 && rready === 1'b1) begin
      e = (rq.size() > 0) ? rq.pop_front() : 66'h0;
      comparisons++;
      if (rresp !== e[65:64] || (rdata & e[63:32]) !== e[31:0]) begin
        num_errors++;
        $display("BAD %0t read %h resp %h expected %h", $time, rdata, rresp, e[31:0]);
      end
    end
  end
  // ----------------------------------------
  // AXI4-Lite master tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d | ($urandom() & 32'hffffffc0);
    wstrb <= s | (4'($urandom()) & 4'he);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awvalid === 1'b1 && awready === 1'b1) begin
        awvalid <= 1'b0;
        aw_done = 1'b1;
      end
      if (wvalid === 1'b1 && wready === 1'b1) begin
        wvalid <= 1'b0;
        w_done = 1'b1;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m,
                    input logic [1:0] r);
    rq.push_back({r, m, x});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rready <= 1'b0;
  endtask
  // Status with mask; bits mirror the output pins
  task automatic chk(input logic [31:0] x, input logic [31:0] m);
    rd(`PM_ADDR_STAT, x, m, `PM_RESP_OK);
  endtask
  // Synchroniser plus output register need a few edges
  task automatic pins(input logic t, input logic b, input logic a = 1'b1,
                      input logic c = 1'b1);
    i_press.set_pins(t, b, a, c);
    repeat (6) @(posedge aclk);
  endtask
  task automatic clear(input int n);
    i_press.pulse(n);
    repeat (8) @(posedge aclk);
  endtask
  // One press cycle with n bottom rises, drive started in the top area
  task automatic cyc(input int n, input logic [31:0] x);
    i_press.set_drive(1'b0);
    i_press.set_drive(1'b1);
    repeat (3) @(posedge aclk);
    pins(1'b0, 1'b0);
    chk(32'h01, 32'h07);
    for (int i = 0; i < n; i++) begin
      pins(1'b0, 1'b1);
      if (i == 0) chk(32'h04, 32'h06);
      if (i < n - 1) pins(1'b0, 1'b0);
    end
    pins(1'b1, (n > 0));
    pins(1'b1, 1'b0);
    chk(x, 32'h7f);
  endtask
  task automatic do_reset();
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
  endtask
  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    aresetn = 1'b0;
    ce = 1'b1;
    void'($urandom(32'h1ac584e6));
    do_reset();
    rd(`PM_ADDR_CTRL, 32'h0, 32'hffffffff, `PM_RESP_OK);
    rd(4'h8, 32'h0, 32'hffffffff, `PM_RESP_DEC);
    wr(`PM_ADDR_CTRL, 32'h09, 4'hf);
    wr(`PM_ADDR_CTRL, 32'h3f, 4'h0);
    wr(`PM_ADDR_STAT, 32'h7f, 4'hf);
    rd(`PM_ADDR_CTRL, 32'h09, 32'hffffffff, `PM_RESP_OK);
    chk(32'h03, 32'h7f);
    cyc(1, 32'h03);
    cyc(0, 32'h58);
    clear(10);
    chk(32'h58, 32'h7f);
    clear($urandom_range(21, 150));
    chk(32'h03, 32'h7f);
    wr(`PM_ADDR_CTRL, 32'h0b, 4'hf);
    i_press.set_drive(1'b0);
    pins(1'b0, 1'b0);
    chk(32'h68, 32'h7f);
    pins(1'b1, 1'b0);
    clear(30);
    clear(250);
    chk(32'h68, 32'h7f);
    clear($urandom_range(41, 150));
    chk(32'h03, 32'h7f);
    // Clock enable low: the permit drop must not reach the output until ce returns
    @(posedge aclk);
    ce <= 1'b0;
    i_press.set_permit(1'b0);
    repeat ($urandom_range(6, 20)) @(posedge aclk);
    @(negedge aclk);
    comparisons++;
    if (press_permit !== 1'b1) begin
      num_errors++;
      $display("BAD %0t outputs moved while ce low", $time);
    end
    @(posedge aclk);
    ce <= 1'b1;
    repeat (6) @(posedge aclk);
    chk(32'h00, 32'h01);
    i_press.set_permit(1'b1);
    repeat (6) @(posedge aclk);
    chk(32'h01, 32'h01);
    wr(`PM_ADDR_CTRL, 32'h0d, 4'hf);
    cyc(2, 32'h03);
    cyc(3, 32'h58);
    clear(30);
    wr(`PM_ADDR_CTRL, 32'h19, 4'hf);
    pins(1'b1, 1'b0, 1'b0);
    chk(32'h58, 32'h7f);
    pins(1'b1, 1'b0);
    clear(30);
    wr(`PM_ADDR_CTRL, 32'h29, 4'hf);
    pins(1'b1, 1'b0, 1'b1, 1'b0);
    pins(1'b0, 1'b0, 1'b1, 1'b0);
    chk(32'h58, 32'h7f);
    pins(1'b1, 1'b0);
    clear(30);
    chk(32'h03, 32'h7f);
    wr(`PM_ADDR_CTRL, 32'h08, 4'hf);
    cyc(0, 32'h58);
    clear(30);
    chk(32'h58, 32'h7f);
    do_reset();
    rd(`PM_ADDR_CTRL, 32'h0, 32'hffffffff, `PM_RESP_OK);
    wr(`PM_ADDR_CTRL, 32'h01, 4'hf);
    cyc(0, 32'h18);
    test_done();
  end
  // Hang guard, far beyond the 1000 to 1300 cycles the run needs
  initial begin
    repeat (40000) @(posedge aclk);
    num_errors++;
    test_done();
  end
endmodule
`default_nettype wire
